/* File: rtl/ffr_pkg.sv */
package ffr_pkg;

    // Serial opcodes understood by the register bank.
    localparam logic [7:0] FFR_OP_WR_PARAMS_NV  = 8'h65;
    localparam logic [7:0] FFR_OP_WR_PARAMS_V   = 8'hc0;
    localparam logic [7:0] FFR_OP_WR_PARAMS_V2  = 8'h63;
    localparam logic [7:0] FFR_OP_RD_PARAMS     = 8'h61;
    localparam logic [7:0] FFR_OP_RD_FUNC       = 8'h48;
    localparam logic [7:0] FFR_OP_WR_FUNC       = 8'h42;

    // Function register field positions.
    localparam int FFR_FN_RESET_DIS = 0;
    localparam int FFR_FN_SIDE      = 1;
    localparam int FFR_FN_PROGRAM_SUSPENDED_FLAG      = 2;
    localparam int FFR_FN_ERASE_SUSPENDED_FLAG      = 3;
    localparam int FFR_FN_LOCK_LO   = 4;
    localparam int FFR_FN_LOCK_HI   = 7;

    // Read-parameter field positions.
    localparam int FFR_RP_PIN_SEL   = 7;
    localparam int FFR_RP_DUMMY_HI  = 6;
    localparam int FFR_RP_DUMMY_LO  = 3;
    localparam int FFR_RP_WRAP      = 2;
    localparam int FFR_RP_BURST_HI  = 1;
    localparam int FFR_RP_BURST_LO  = 0;

    // Reset values and masks.
    localparam logic [7:0] FFR_FN_RESET      = 8'h00;
    localparam logic [7:0] FFR_FN_OTP_MASK   = 8'hf3;
    localparam logic [7:0] FFR_RP_RESET      = 8'h00;
    localparam logic [3:0] FFR_DUMMY_DEF_SPI = 4'h8;
    localparam logic [3:0] FFR_DUMMY_DEF_QPI = 4'h6;
    localparam logic [6:0] FFR_BURST_BASE    = 7'h08;

    // Power-up sequencer states, Gray along reset, load, run.
    typedef enum logic [1:0] {
        FFR_ST_RESET = 2'b00,
        FFR_ST_LOAD  = 2'b01,
        FFR_ST_RUN   = 2'b11
    } ffr_state_e;

endpackage : ffr_pkg

/* File: rtl/ffr_regs.sv */
`timescale 1ns/1ps
// What this block does
// - Function bit 0 moves reset onto shared pin.
// - Function bit 1 picks top or bottom protection.
// - Program suspend flag set, cleared on resume.
// - Erase suspend flag set, cleared on resume.
// - Bits 4..7 lock information rows when set.
// - One-time bits never clear once set.
// - Bits 7..1 reset zero; bit 0 per variant.
// - Volatile parameters loaded from persistent copy.
// - Parameter bit 7 selects hold or reset.
// - Quad or four-line mode ignores bit 7.
// - Dedicated-reset variants keep shared pin hold unless function bit 0 is set.
// - Parameter bits 6..3 give dummy cycle count.
// - Opcodes 65h, C0h, 63h write parameters.
// - Bits 1..0 select 8 to 64 bytes.
// - Bit 2 enables wrap at burst boundary.
// - All parameter bits default to zero.
// - Zero dummy field uses command default count.
// - Quad enable turns protect, hold pins into data.
module ffr_regs
    import ffr_pkg::*;
#(
    parameter logic RESET_DIS_DEFAULT   = 1'b0,  // Function bit 0 default for this variant.
    parameter logic HAS_DEDICATED_RESET = 1'b1   // Variant has its own reset pin.
) (
    input  wire logic       clk_sys,                  // System clock, 100 MHz.
    input  wire logic       rst_n,                    // Power-on reset, synchronous, active low.
    input  wire logic       clk_en,                   // Clock enable, freezes all state when low.
    input  wire logic       sck,                      // Serial clock pin.
    input  wire logic       cs_n,                     // Chip select pin, active low.
    input  wire logic       si,                       // Serial data in pin.
    output logic            so,                       // Serial data out.
    output logic            so_oe,                    // Serial data out enable.
    input  wire logic       reset_pin_n,              // Dedicated reset pin, active low.
    input  wire logic       hold_reset_pin_n,         // Shared hold or reset pin, active low.
    input  wire logic       quad_enable,              // Quad enable from status logic.
    input  wire logic       four_line_command_mode,   // Four-line command mode active.
    input  wire logic       prog_busy,                // Program operation in progress.
    input  wire logic       erase_busy,               // Erase operation in progress.
    input  wire logic       suspend_cmd,              // Suspend command pulse.
    input  wire logic       resume_cmd,               // Resume command pulse.
    output logic            device_reset,             // Device reset active from a pin.
    output logic            dedicated_reset_off,      // Dedicated reset pin disabled.
    output logic            protect_region_side,      // Protection from bottom when high.
    output logic            program_suspended_flag,   // Program suspended.
    output logic            erase_suspended_flag,     // Erase suspended.
    output logic      [3:0] info_row_lock,            // Information row locks, row 0 in bit 0.
    output logic            shared_pin_is_reset,      // Shared pin acts as reset.
    output logic            shared_pin_is_hold,       // Shared pin acts as hold.
    output logic            pins_are_data,            // Protect and hold pins carry data.
    output logic      [3:0] read_dummy_cycles,        // Effective fast-read dummy count.
    output logic            wrap_enable_bit,          // Wrap within burst boundary.
    output logic      [1:0] burst_length,             // Burst length code.
    output logic      [6:0] wrap_boundary_bytes,      // Burst length in bytes.
    output logic      [7:0] read_parameters,          // Volatile parameter copy.
    output logic      [7:0] read_params_persistent    // Persistent parameter copy.
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and serial receiver.

    logic       sck_s;
    logic       cs_n_s;
    logic       si_s;
    logic       rst_pin_s;
    logic       hold_pin_s;
    logic       rx_run;
    logic       sck_fall;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic [1:0] byte_idx;

    ffr_sync #(
        .W (5)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .d       ({sck, cs_n, si, reset_pin_n, hold_reset_pin_n}),
        .init    (5'h0b),
        .q       ({sck_s, cs_n_s, si_s, rst_pin_s, hold_pin_s})
    );

    ffr_serial_rx u_rx (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n & ~device_reset),
        .clk_en     (clk_en),
        .sck_s      (sck_s),
        .cs_n_s     (cs_n_s),
        .si_s       (si_s),
        .run        (rx_run),
        .sck_fall   (sck_fall),
        .byte_valid (byte_valid),
        .byte_data  (byte_data),
        .byte_idx   (byte_idx)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.

    ffr_state_e state;
    logic [7:0] fn_otp;
    logic [7:0] opcode;
    logic [7:0] tx_shift;
    logic       tx_on;
    logic       pins_quad;
    logic       shared_reset_sel;
    logic       dev_rst_now;
    logic       write_byte;

    // Opcode decoding shared by the read and write paths.
    function automatic logic is_read_op(input logic [7:0] op);
        is_read_op = (op == FFR_OP_RD_PARAMS) || (op == FFR_OP_RD_FUNC);
    endfunction : is_read_op

    function automatic logic is_vol_write(input logic [7:0] op);
        is_vol_write = (op == FFR_OP_WR_PARAMS_V) || (op == FFR_OP_WR_PARAMS_V2);
    endfunction : is_vol_write

    // Pin function selection, shared by reset detection and the outputs.
    // quad overrides pin
    assign pins_quad = quad_enable | four_line_command_mode;
    assign shared_reset_sel = !pins_quad &&
                              (HAS_DEDICATED_RESET ? fn_otp[FFR_FN_RESET_DIS] : read_parameters[FFR_RP_PIN_SEL]);
    assign dev_rst_now = (shared_reset_sel && !hold_pin_s) ||
                         (HAS_DEDICATED_RESET && !fn_otp[FFR_FN_RESET_DIS] && !rst_pin_s);
    assign rx_run      = pins_quad || shared_reset_sel || hold_pin_s;
    assign write_byte  = byte_valid && (byte_idx == 2'h1) && (state == FFR_ST_RUN);

    // Device reset level from whichever pin currently owns the reset function.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            device_reset <= 1'b0;
        end else if (clk_en) begin
            device_reset <= dev_rst_now;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= FFR_ST_RESET;
        end else if (clk_en) begin
            case (state)
                FFR_ST_RESET: begin
                    state <= FFR_ST_LOAD;
                end
                FFR_ST_LOAD: begin
                    state <= device_reset ? FFR_ST_LOAD : FFR_ST_RUN;
                end
                FFR_ST_RUN: begin
                    state <= device_reset ? FFR_ST_LOAD : FFR_ST_RUN;
                end
                default: begin
                    state <= FFR_ST_RESET;
                end
            endcase
        end
    end

    // One-time-programmable function bits; suspend positions never stored here.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fn_otp <= FFR_FN_RESET | {7'h00, RESET_DIS_DEFAULT};
        end else if (clk_en && write_byte && opcode == FFR_OP_WR_FUNC) begin
            fn_otp <= fn_otp | (byte_data & FFR_FN_OTP_MASK);
        end
    end

    // Suspend flags follow the array controller and clear on device reset; a set beats a resume clear.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            program_suspended_flag <= 1'b0;
            erase_suspended_flag   <= 1'b0;
        end else if (clk_en) begin
            if (device_reset) begin
                program_suspended_flag <= 1'b0;
                erase_suspended_flag   <= 1'b0;
            end else begin
                if (suspend_cmd && prog_busy) begin
                    program_suspended_flag <= 1'b1;
                end else if (resume_cmd) begin
                    program_suspended_flag <= 1'b0;
                end
                if (suspend_cmd && erase_busy) begin
                    erase_suspended_flag <= 1'b1;
                end else if (resume_cmd) begin
                    erase_suspended_flag <= 1'b0;
                end
            end
        end
    end

    // Persistent parameter copy survives pin resets.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            read_params_persistent <= FFR_RP_RESET;
        end else if (clk_en && write_byte && opcode == FFR_OP_WR_PARAMS_NV) begin
            read_params_persistent <= byte_data;
        end
    end

    // Volatile parameter copy.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            read_parameters <= FFR_RP_RESET;
        end else if (clk_en) begin
            if (state == FFR_ST_LOAD) begin
                read_parameters <= read_params_persistent;
            end else if (write_byte && is_vol_write(opcode)) begin
                read_parameters <= byte_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial command handling.

    // Opcode capture and read data shifting, MSB first on falling edges.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            opcode   <= 8'h00;
            tx_shift <= 8'h00;
            tx_on    <= 1'b0;
            so       <= 1'b0;
            so_oe    <= 1'b0;
        end else if (clk_en) begin
            if (cs_n_s || device_reset) begin
                opcode <= 8'h00;
                tx_on  <= 1'b0;
                so_oe  <= 1'b0;
                so     <= 1'b0;
            end else if (byte_valid && byte_idx == 2'h0 && state == FFR_ST_RUN) begin
                opcode <= byte_data;
                tx_on  <= is_read_op(byte_data);
                if (byte_data == FFR_OP_RD_FUNC) begin
                    tx_shift <= {fn_otp[7:4], erase_suspended_flag, program_suspended_flag, fn_otp[1:0]};
                end else begin
                    tx_shift <= read_parameters;
                end
            end else if (sck_fall && tx_on) begin
                so       <= tx_shift[7];
                so_oe    <= 1'b1;
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded configuration outputs, all registered.

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dedicated_reset_off <= 1'b0;
            protect_region_side <= 1'b0;
            info_row_lock       <= 4'h0;
            shared_pin_is_reset <= 1'b0;
            shared_pin_is_hold  <= 1'b0;
            pins_are_data       <= 1'b0;
            read_dummy_cycles   <= FFR_DUMMY_DEF_SPI;
            wrap_enable_bit     <= 1'b0;
            burst_length        <= 2'h0;
            wrap_boundary_bytes <= FFR_BURST_BASE;
        end else if (clk_en) begin
            dedicated_reset_off <= fn_otp[FFR_FN_RESET_DIS];
            protect_region_side <= fn_otp[FFR_FN_SIDE];
            info_row_lock       <= fn_otp[FFR_FN_LOCK_HI:FFR_FN_LOCK_LO];
            shared_pin_is_reset <= shared_reset_sel;
            shared_pin_is_hold  <= !pins_quad && !shared_reset_sel;
            pins_are_data       <= quad_enable;
            if (read_parameters[FFR_RP_DUMMY_HI:FFR_RP_DUMMY_LO] != 4'h0) begin
                read_dummy_cycles <= read_parameters[FFR_RP_DUMMY_HI:FFR_RP_DUMMY_LO];
            end else if (four_line_command_mode) begin
                read_dummy_cycles <= FFR_DUMMY_DEF_QPI;
            end else begin
                read_dummy_cycles <= FFR_DUMMY_DEF_SPI;
            end
            wrap_enable_bit     <= read_parameters[FFR_RP_WRAP];
            burst_length        <= read_parameters[FFR_RP_BURST_HI:FFR_RP_BURST_LO];
            wrap_boundary_bytes <= FFR_BURST_BASE << read_parameters[FFR_RP_BURST_HI:FFR_RP_BURST_LO];
        end
    end

endmodule : ffr_regs

/* File: rtl/ffr_serial_rx.sv */
`timescale 1ns/1ps
module ffr_serial_rx (
    input  wire logic       clk_sys,     // System clock.
    input  wire logic       rst_n,       // Synchronous reset, active low.
    input  wire logic       clk_en,      // Clock enable.
    input  wire logic       sck_s,       // Synchronised serial clock.
    input  wire logic       cs_n_s,      // Synchronised chip select, active low.
    input  wire logic       si_s,        // Synchronised serial data in.
    input  wire logic       run,         // Low pauses the frame.
    output logic            sck_fall,    // Serial clock falling edge pulse.
    output logic            byte_valid,  // One-cycle pulse per received byte.
    output logic      [7:0] byte_data,   // Received byte, first bit is MSB.
    output logic      [1:0] byte_idx     // Index of received byte in frame.
);

    logic       sck_q;
    logic       sck_rise;
    logic [2:0] bit_cnt;
    logic [6:0] shreg;

    assign sck_rise = sck_s & ~sck_q & ~cs_n_s & run;
    assign sck_fall = ~sck_s & sck_q & ~cs_n_s & run;

    // Edge detector history of the synchronised clock.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
        end else if (clk_en) begin
            sck_q <= sck_s;
        end
    end

    // Bit shifting on rising edges; the frame restarts when select rises.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bit_cnt    <= 3'h0;
            shreg      <= 7'h00;
            byte_valid <= 1'b0;
            byte_data  <= 8'h00;
            byte_idx   <= 2'h0;
        end else if (clk_en) begin
            byte_valid <= 1'b0;
            if (cs_n_s) begin
                bit_cnt  <= 3'h0;
                byte_idx <= 2'h0;
            end else if (sck_rise) begin
                bit_cnt <= bit_cnt + 3'h1;
                shreg   <= {shreg[5:0], si_s};
                if (bit_cnt == 3'h7) begin
                    byte_valid <= 1'b1;
                    byte_data  <= {shreg, si_s};
                end
            end else if (byte_valid && byte_idx != 2'h3) begin
                byte_idx <= byte_idx + 2'h1;
            end
        end
    end

endmodule : ffr_serial_rx

/* File: rtl/ffr_sync.sv */
`timescale 1ns/1ps
module ffr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,  // System clock.
    input  wire logic         rst_n,    // Synchronous reset, active low.
    input  wire logic         clk_en,   // Clock enable.
    input  wire logic [W-1:0] d,        // Asynchronous inputs.
    input  wire logic [W-1:0] init,     // Idle level after reset.
    output logic      [W-1:0] q         // Synchronised outputs.
);

    logic [W-1:0] meta;

    // Two-stage synchroniser; reset to pin idle levels so no false edge or reset follows.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta <= init;
            q    <= init;
        end else if (clk_en) begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : ffr_sync

/* File: tb/ffr_host_model.sv */
`timescale 1ns/1ps
module ffr_host_model (
    output logic sck,    // Serial clock, still between frames.
    output logic cs_n,   // Chip select, active low.
    output logic si,     // Data to the device.
    input  wire logic so,    // Data from the device.
    input  wire logic so_oe  // Device drives so while high.
);
    logic last_so;  // Last level the device drove.
    logic so_line;  // Level seen on the wire.

    // A released wire shows the inverse of its last level.
    always @(so or so_oe) if (so_oe) last_so = so;
    assign so_line = so_oe ? so : ~last_so;

    // Idle levels at time zero.
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        last_so = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // opcode then data
    task automatic frame(input logic [7:0] op, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {op, wd};
        rd = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            si = sh[15-i];
            #62.5;
            sck = 1'b1;
            if (i > 7) rd[15-i] = so_line;
            #62.5;
            sck = 1'b0;
        end
        #62.5;
        cs_n = 1'b1;
        si = ~si;
        #100;
    endtask : frame
endmodule : ffr_host_model

/* File: tb/ffr_regs_sva.sv */
`timescale 1ns/1ps
module ffr_regs_sva
    import ffr_pkg::*;
(
    input wire logic       clk_sys,                 // Clock.
    input wire logic       rst_n,                   // Reset, active low.
    input wire logic       quad_enable,             // Quad enable.
    input wire logic       four_line_command_mode,  // Four-line mode.
    input wire logic       prog_busy,               // Program busy.
    input wire logic       erase_busy,              // Erase busy.
    input wire logic       suspend_cmd,             // Suspend pulse.
    input wire logic       resume_cmd,              // Resume pulse.
    input wire logic       device_reset,            // Pin reset active.
    input wire logic       dedicated_reset_off,     // Function bit 0.
    input wire logic       protect_region_side,     // Function bit 1.
    input wire logic       program_suspended_flag,  // Function bit 2.
    input wire logic       erase_suspended_flag,    // Function bit 3.
    input wire logic [3:0] info_row_lock,           // Function bits 7:4.
    input wire logic       shared_pin_is_reset,     // Shared pin is reset.
    input wire logic       shared_pin_is_hold,      // Shared pin is hold.
    input wire logic       pins_are_data,           // Pins carry data.
    input wire logic [3:0] read_dummy_cycles,       // Dummy count.
    input wire logic       wrap_enable_bit,         // Wrap enable.
    input wire logic [1:0] burst_length,            // Burst code.
    input wire logic [6:0] wrap_boundary_bytes,     // Burst bytes.
    input wire logic [7:0] read_parameters          // Volatile copy.
);
    default clocking dflt @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // One-time bits gathered for one check.
    logic [5:0] otp_bits;
    assign otp_bits = {info_row_lock, protect_region_side, dedicated_reset_off};

    ////////////////////////////////////////////////////////////////////////////////
    // dummy and burst decode, one-time bit, suspend flag and pin role checks
    chk_dummy_decode: assert property ($stable(read_parameters) && $stable(four_line_command_mode) |->
        read_dummy_cycles == ((read_parameters[6:3] != 4'h0) ? read_parameters[6:3] :
        (four_line_command_mode ? 4'h6 : 4'h8))) else $error("dummy count wrong");
    chk_burst_decode: assert property ($stable(read_parameters) |-> burst_length == read_parameters[1:0] &&
        wrap_enable_bit == read_parameters[2] && wrap_boundary_bytes == (7'h08 << read_parameters[1:0]))
        else $error("burst decode wrong");
    chk_otp_sticky: assert property (1'b1 |=> (otp_bits & $past(otp_bits)) == $past(otp_bits))
        else $error("one-time bit cleared");
    chk_program_suspended_flag_set: assert property (suspend_cmd && prog_busy && !device_reset |=> program_suspended_flag)
        else $error("program flag not set");
    chk_erase_suspended_flag_set: assert property (suspend_cmd && erase_busy && !device_reset |=> erase_suspended_flag)
        else $error("erase flag not set");
    chk_resume_clear: assert property (resume_cmd && !suspend_cmd |=>
        !program_suspended_flag && !erase_suspended_flag) else $error("flag not cleared");
    chk_flag_cause: assert property ($rose(program_suspended_flag) || $rose(erase_suspended_flag) |->
        $past(suspend_cmd)) else $error("flag rose without suspend");
    chk_pins_data: assert property (1'b1 |=> pins_are_data == $past(quad_enable))
        else $error("pin data role wrong");
    chk_quad_roles: assert property (quad_enable [*3] |-> !shared_pin_is_reset && !shared_pin_is_hold)
        else $error("shared pin role in quad");
    chk_hold_ded: assert property ((!quad_enable && !four_line_command_mode && !dedicated_reset_off) [*3]
        |-> shared_pin_is_hold && !shared_pin_is_reset) else $error("shared pin not hold");

    // Main scenarios.
    cov_program_suspended_flag: cover property (suspend_cmd && prog_busy ##1 program_suspended_flag);
    cov_reset: cover property ($rose(device_reset));
    cov_moved: cover property ($rose(dedicated_reset_off));
endmodule : ffr_regs_sva

bind ffr_regs ffr_regs_sva chk_u (.*);

/* File: tb/test_flash_function_read_param_regs.sv */
`timescale 1ns/1ps
module test_flash_function_read_param_regs;
    import ffr_pkg::*;
    logic       clk_sys, rst_n, clk_en, sck, cs_n, si, so, so_oe, reset_pin_n, hold_reset_pin_n;
    logic       quad_enable, four_line_command_mode, prog_busy, erase_busy, suspend_cmd, resume_cmd;
    logic       device_reset, dedicated_reset_off, protect_region_side, program_suspended_flag;
    logic       erase_suspended_flag, shared_pin_is_reset, shared_pin_is_hold, pins_are_data, wrap_enable_bit;
    logic [1:0] burst_length;
    logic [3:0] info_row_lock, read_dummy_cycles;
    logic [6:0] wrap_boundary_bytes;
    logic [7:0] read_parameters, read_params_persistent, rp_exp, nv_exp, fn_exp, wd, rd;
    integer     seed, miscompares, num_checks;

    ffr_regs #(.RESET_DIS_DEFAULT(1'b0), .HAS_DEDICATED_RESET(1'b1)) dut_u (.*);
    ffr_host_model host_u (.*);

    // System clock, 10 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Expected dummy count.
    function automatic logic [3:0] dummy_exp(input logic [7:0] rp, input logic q4);
        return (rp[6:3] != 4'h0) ? rp[6:3] : (q4 ? 4'h6 : 4'h8);
    endfunction : dummy_exp

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_clk

    // Reads both registers back and checks them.
    task automatic chk_regs(input string name);
        host_u.frame(FFR_OP_RD_PARAMS, 8'h00, rd);
        check("rd params", rd, rp_exp);
        check("params", read_parameters, rp_exp);
        check("dummy", {4'h0, read_dummy_cycles}, {4'h0, dummy_exp(rp_exp, 1'b0)});
        check("burst", {5'h00, wrap_enable_bit, burst_length}, {5'h00, rp_exp[2:0]});
        check("bytes", {1'b0, wrap_boundary_bytes}, {1'b0, 7'h08 << rp_exp[1:0]});
        host_u.frame(FFR_OP_RD_FUNC, 8'h00, rd);
        check("rd func", rd, fn_exp);
        check("func", {info_row_lock, erase_suspended_flag, program_suspended_flag, protect_region_side,
            dedicated_reset_off}, fn_exp);
        $display("test %s done", name);
    endtask : chk_regs

    // One suspend or resume pulse.
    task automatic pulse(input logic sus, input logic kind);
        @(negedge clk_sys);
        prog_busy = !kind;
        erase_busy = kind;
        suspend_cmd = sus;
        resume_cmd = !sus;
        @(negedge clk_sys);
        suspend_cmd = 1'b0;
        resume_cmd = 1'b0;
        wait_clk(2);
    endtask : pulse

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    // Cuts a hang short.
    initial begin
        #400000;
        miscompares++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        seed = 32530;
        miscompares = 0;
        num_checks = 0;
        {rst_n, quad_enable, four_line_command_mode, prog_busy, erase_busy, suspend_cmd, resume_cmd} = 7'h00;
        {clk_en, reset_pin_n, hold_reset_pin_n} = 3'h7;
        {rp_exp, nv_exp, fn_exp} = 24'h0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        wait_clk(6);
        chk_regs("reset");
        check("nv reset", read_params_persistent, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wd = 8'($random(seed));
            if (k == 0) wd = 8'h80;
            if (k == 1) wd = 8'h0c;
            if (k == 7) wd = 8'hff;
            wd[1:0] = k[1:0];
            rp_exp = wd;
            host_u.frame(k[0] ? FFR_OP_WR_PARAMS_V2 : FFR_OP_WR_PARAMS_V, wd, rd);
            chk_regs("volatile");
            check("nv kept", read_params_persistent, 8'h00);
            check("hold", {7'h00, shared_pin_is_hold}, 8'h01);
            wait_clk(1);
            four_line_command_mode = 1'b1;
            wait_clk(3);
            check("dummy qpi", {4'h0, read_dummy_cycles}, {4'h0, dummy_exp(rp_exp, 1'b1)});
            four_line_command_mode = 1'b0;
            quad_enable = 1'b1;
            wait_clk(4);
            check("quad", {5'h00, pins_are_data, shared_pin_is_reset, shared_pin_is_hold}, 8'h04);
            quad_enable = 1'b0;
            wait_clk(4);
        end
        nv_exp = 8'($random(seed));
        host_u.frame(FFR_OP_WR_PARAMS_NV, nv_exp, rd);
        wait_clk(1);
        check("nv", read_params_persistent, nv_exp);
        chk_regs("persistent");
        reset_pin_n = 1'b0;
        wait_clk(6);
        check("pin reset", {7'h00, device_reset}, 8'h01);
        reset_pin_n = 1'b1;
        wait_clk(8);
        rp_exp = nv_exp;
        chk_regs("reload");
        for (int k = 0; k < 2; k++) begin
            pulse(1'b1, k[0]);
            fn_exp[2+k] = 1'b1;
            host_u.frame(FFR_OP_WR_FUNC, 8'h00, rd);
            chk_regs("suspend");
            pulse(1'b0, k[0]);
            fn_exp[2+k] = 1'b0;
            host_u.frame(FFR_OP_WR_FUNC, 8'h0c, rd);
            chk_regs("resume");
        end
        wd = 8'($random(seed));
        wd[0] = 1'b0;
        fn_exp = wd & 8'hf2;
        host_u.frame(FFR_OP_WR_FUNC, wd, rd);
        chk_regs("otp set");
        host_u.frame(FFR_OP_WR_FUNC, 8'h00, rd);
        chk_regs("otp clear");
        host_u.frame(FFR_OP_WR_FUNC, 8'h01, rd);
        fn_exp[0] = 1'b1;
        chk_regs("reset move");
        check("moved", {5'h00, pins_are_data, shared_pin_is_reset, shared_pin_is_hold}, 8'h02);
        wait_clk(1);
        reset_pin_n = 1'b0;
        wait_clk(6);
        check("ded off", {7'h00, device_reset}, 8'h00);
        reset_pin_n = 1'b1;
        hold_reset_pin_n = 1'b0;
        wait_clk(6);
        check("shared rst", {7'h00, device_reset}, 8'h01);
        hold_reset_pin_n = 1'b1;
        wait_clk(8);
        chk_regs("final");
        give_verdict();
    end
endmodule : test_flash_function_read_param_regs
